// ### hdl/tcrb_pkg.sv
// package for the timer2 capture/reload/baud block: register map, fields, constants
package tcrb_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] TCRB_IDX_CONTROL = 8'hc8;
  localparam logic [7:0] TCRB_IDX_MODE = 8'hc9;
  localparam logic [7:0] TCRB_IDX_CAP_LOW = 8'hca;
  localparam logic [7:0] TCRB_IDX_CAP_HIGH = 8'hcb;
  localparam logic [7:0] TCRB_IDX_CNT_LOW = 8'hcc;
  localparam logic [7:0] TCRB_IDX_CNT_HIGH = 8'hcd;
  localparam logic [7:0] TCRB_IDX_AUX = 8'hd0;
  localparam logic [7:0] TCRB_IDX_IRQ_STATUS = 8'hd1;
  localparam logic [7:0] TCRB_IDX_IRQ_MASK = 8'hd2;
  localparam int TCRB_ADDR_W = 12;
  // mode register bit positions
  localparam int TCRB_MODE_CLR_BIT = 3;
  localparam int TCRB_MODE_DOWN_COUNT_ENABLE_BIT = 0;
  // aux register bit positions
  localparam int TCRB_AUX_RATE_BIT = 0;
  localparam int TCRB_AUX_IE_BIT = 1;
  // interrupt status bit positions
  localparam int TCRB_IRQ_OVF_BIT = 0;
  localparam int TCRB_IRQ_EXT_BIT = 1;
  // reset values
  localparam logic [7:0] TCRB_RST_BYTE = 8'h00;
  localparam logic [15:0] TCRB_RST_WORD = 16'h0000;
  // tick dividers in core clocks
  localparam logic [3:0] TCRB_DIV_SLOW = 4'hc;
  localparam logic [3:0] TCRB_DIV_FAST = 4'h4;
  localparam logic [3:0] TCRB_DIV_BAUD = 4'h2;
  // axi responses
  localparam logic [1:0] TCRB_RESP_OKAY = 2'h0;
  localparam logic [1:0] TCRB_RESP_SLVERR = 2'h2;
  // control register layout, msb first
  typedef struct packed {
    logic overflowFlag;
    logic externalEdgeFlag;
    logic rxBaudSelect;
    logic txBaudSelect;
    logic extTriggerEnable;
    logic runControl;
    logic counterSelect;
    logic captureReloadSelect;
  } tcrb_ctrl_t;
  // filtered pin sample
  typedef struct packed {
    logic level;
    logic fall;
  } tcrb_pin_t;
endpackage

// ### hdl/tcrb_timer2.sv
// sixteen-bit timer2 with capture, auto-reload, up/down and baud generator, axi4-lite slave
//
// Overview of operation
// - overflow or down-count match sets flag, not baud
// - hardware never clears overflow flag; software may
// - edge or overflow sets external flag per mode
// - flag or edge raises enabled timer interrupt
// - receive time base selects timer1 or this overflow
// - transmit time base selects timer1 or this overflow
// - trigger edge captures or reloads unless baud or up/down mode
// - run control off stops counting; trigger edges still reload or clear the count
// - baud mode advances every two clocks
// - timer ticks internally or counts pin falling edges
// - baud mode auto-reloads on every overflow
// - reload mode reloads on up overflow, and on edge only with down enable clear
// - capture mode copies count on trigger edge
// - capture may clear count in the same cycle as it copies
// - down enable and pin set direction
// - capture registers receive and supply reload value
// - interrupt enable bit gates timer request
`timescale 1ns/1ps
`default_nettype none
module tcrb_timer2
  import tcrb_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [TCRB_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [TCRB_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic extTriggerPin,
  input wire logic countInputPin,
  input wire logic timer1Overflow,
  output logic rxBaudClk,
  output logic txBaudClk,
  output logic timerIrqReq,
  output logic irqOut
);
  // register state
  tcrb_ctrl_t ctrl; // control register
  logic [7:0] modeReg; // mode register
  logic [15:0] capture; // capture / reload value
  logic [15:0] count; // live count
  logic [7:0] aux; // tick rate and interrupt enable
  logic [1:0] irqStatus; // sticky events
  logic [1:0] irqMask; // event mask
  // bus state
  logic [TCRB_ADDR_W-1:0] awAddr; // held write address
  logic awHeld; // write address taken
  logic [31:0] wData; // held write data
  logic [3:0] wStrb; // held write strobes
  logic wHeld; // write data taken
  // pin synchronisers
  logic [2:0] extSync; // trigger pin chain
  logic [2:0] cntSync; // count pin chain
  logic extLevel; // filtered trigger level
  logic cntLevel; // filtered count level
  tcrb_pin_t extPin; // trigger level and fall
  tcrb_pin_t cntPin; // count level and fall
  // prescaler
  logic [3:0] divCnt; // core clock divider
  logic [3:0] divLimit; // current divide ratio
  logic divTick; // one-cycle enable from divider
  // decoded behaviour
  logic baudMode; // either baud select set
  logic upDown; // up/down auto-reload mode
  logic countUp; // present direction
  logic advance; // count moves this cycle
  logic ovfEvent; // overflow or down match
  logic edgeEvent; // accepted trigger edge
  logic captureEvent; // capture on edge
  logic reloadEdge; // reload on edge
  logic ovfSet; // hardware sets overflow flag
  logic extSet; // hardware sets external flag
  logic [15:0] next_count; // count after this cycle
  logic doWrite; // write performed this cycle
  logic [7:0] wrIdx; // write register index
  logic [7:0] wrByte; // write data byte
  logic wrOk; // write hits a register
  logic [7:0] rdIdx; // read register index
  logic [7:0] rdByte; // read data byte
  logic rdOk; // read hits a register

  // three-flop chains on the two pins
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      extSync <= 3'h7;
      cntSync <= 3'h7;
    end else begin
      extSync <= {extSync[1:0], extTriggerPin};
      cntSync <= {cntSync[1:0], countInputPin};
    end
  end

  // filtered levels change once stages two and three agree
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      extLevel <= 1'b1;
      cntLevel <= 1'b1;
    end else begin
      if (extSync[1] == extSync[2]) extLevel <= extSync[2];
      if (cntSync[1] == cntSync[2]) cntLevel <= cntSync[2];
    end
  end

  // falling edges as filtered level drops
  always_comb begin
    extPin.level = extLevel;
    extPin.fall = extLevel && (extSync[1] == extSync[2]) && !extSync[2];
    cntPin.level = cntLevel;
    cntPin.fall = cntLevel && (cntSync[1] == cntSync[2]) && !cntSync[2];
  end

  // divide ratio: baud fixed at two, else tick rate select
  always_comb begin
    if (baudMode) begin
      divLimit = TCRB_DIV_BAUD;
    end else if (aux[TCRB_AUX_RATE_BIT]) begin
      divLimit = TCRB_DIV_FAST;
    end else begin
      divLimit = TCRB_DIV_SLOW;
    end
  end

  // prescaler produces a one-cycle enable
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      divCnt <= 4'h0;
    end else if (divTick || !ctrl.runControl) begin
      divCnt <= 4'h0;
    end else begin
      divCnt <= divCnt + 4'h1;
    end
  end
  assign divTick = (divCnt >= divLimit - 4'h1);

  // mode decode and counting events
  always_comb begin
    baudMode = ctrl.rxBaudSelect || ctrl.txBaudSelect;
    upDown = modeReg[TCRB_MODE_DOWN_COUNT_ENABLE_BIT] && !ctrl.captureReloadSelect && !baudMode;
    countUp = !upDown || extPin.level;
    // baud ignores counter select; otherwise pick source
    if (!ctrl.runControl) begin
      advance = 1'b0;
    end else if (baudMode) begin
      advance = divTick;
    end else if (ctrl.counterSelect) begin
      advance = cntPin.fall;
    end else begin
      advance = divTick;
    end
    ovfEvent = advance && (countUp ? (count == 16'hffff) : (count == capture));
    edgeEvent = ctrl.extTriggerEnable && !baudMode && extPin.fall;
    captureEvent = edgeEvent && ctrl.captureReloadSelect;
    reloadEdge = edgeEvent && !ctrl.captureReloadSelect && !upDown;
    ovfSet = ovfEvent && !baudMode;
    extSet = captureEvent || reloadEdge || (ovfEvent && upDown);
  end

  // next count value
  always_comb begin
    next_count = count;
    if (captureEvent && modeReg[TCRB_MODE_CLR_BIT]) begin
      next_count = TCRB_RST_WORD;
    end else if (reloadEdge) begin
      next_count = capture;
    end else if (ovfEvent) begin
      if (!countUp) begin
        next_count = 16'hffff;
      end else if (baudMode || !ctrl.captureReloadSelect) begin
        next_count = capture;
      end else begin
        next_count = TCRB_RST_WORD;
      end
    end else if (advance) begin
      next_count = countUp ? count + 16'h0001 : count - 16'h0001;
    end
  end

  // write decode
  always_comb begin
    wrIdx = awAddr[9:2];
    wrByte = wData[7:0];
    wrOk = (awAddr[1:0] == 2'h0) && (awAddr[TCRB_ADDR_W-1:10] == '0) &&
           ((wrIdx >= TCRB_IDX_CONTROL && wrIdx <= TCRB_IDX_CNT_HIGH) ||
            (wrIdx >= TCRB_IDX_AUX && wrIdx <= TCRB_IDX_IRQ_MASK));
    // refused addresses never reach a register, even if the index aliases one
    doWrite = awHeld && wHeld && !s_axi_bvalid && wStrb[0] && wrOk;
  end

  // control register; flags set by hardware win over a software clear
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl <= tcrb_ctrl_t'(TCRB_RST_BYTE);
    end else begin
      if (doWrite && wrIdx == TCRB_IDX_CONTROL) begin
        ctrl <= tcrb_ctrl_t'(wrByte);
      end
      if (ovfSet) ctrl.overflowFlag <= 1'b1;
      if (extSet) ctrl.externalEdgeFlag <= 1'b1;
    end
  end

  // mode and aux registers
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      modeReg <= TCRB_RST_BYTE;
      aux <= TCRB_RST_BYTE;
    end else if (doWrite) begin
      if (wrIdx == TCRB_IDX_MODE) modeReg <= wrByte;
      if (wrIdx == TCRB_IDX_AUX) aux <= wrByte;
    end
  end

  // capture registers: copy on capture, software writes otherwise
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      capture <= TCRB_RST_WORD;
    end else if (captureEvent) begin
      capture <= count;
    end else if (doWrite) begin
      if (wrIdx == TCRB_IDX_CAP_LOW) capture[7:0] <= wrByte;
      if (wrIdx == TCRB_IDX_CAP_HIGH) capture[15:8] <= wrByte;
    end
  end

  // count; a software write to a byte wins over counting
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= TCRB_RST_WORD;
    end else if (doWrite && wrIdx == TCRB_IDX_CNT_LOW) begin
      count[7:0] <= wrByte;
    end else if (doWrite && wrIdx == TCRB_IDX_CNT_HIGH) begin
      count[15:8] <= wrByte;
    end else begin
      count <= next_count;
    end
  end

  // sticky interrupt status, write one to clear, set wins
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      irqStatus <= 2'h0;
      irqMask <= 2'h0;
    end else begin
      if (doWrite && wrIdx == TCRB_IDX_IRQ_MASK) irqMask <= wrByte[1:0];
      if (doWrite && wrIdx == TCRB_IDX_IRQ_STATUS) irqStatus <= irqStatus & ~wrByte[1:0];
      if (ovfSet) irqStatus[TCRB_IRQ_OVF_BIT] <= 1'b1;
      if (extSet) irqStatus[TCRB_IRQ_EXT_BIT] <= 1'b1;
    end
  end

  // interrupt and baud outputs, all registered
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      timerIrqReq <= 1'b0;
      irqOut <= 1'b0;
      rxBaudClk <= 1'b0;
      txBaudClk <= 1'b0;
    end else begin
      timerIrqReq <= aux[TCRB_AUX_IE_BIT] && (ctrl.overflowFlag || ctrl.externalEdgeFlag);
      irqOut <= |(irqStatus & irqMask);
      rxBaudClk <= ctrl.rxBaudSelect ? ovfEvent : timer1Overflow;
      txBaudClk <= ctrl.txBaudSelect ? ovfEvent : timer1Overflow;
    end
  end

  // axi write channel: hold address and data, answer after both
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= '0;
      wData <= 32'h0;
      wStrb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= TCRB_RESP_OKAY;
    end else begin
      s_axi_awready <= !awHeld && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !wHeld && !(s_axi_wvalid && s_axi_wready);
      // address taken
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end
      // data taken
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      // both held: perform and respond
      if (awHeld && wHeld && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrOk ? TCRB_RESP_OKAY : TCRB_RESP_SLVERR;
      end
      // response accepted: release for next write
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        awHeld <= 1'b0;
        wHeld <= 1'b0;
      end
    end
  end

  // read mux
  always_comb begin
    rdIdx = s_axi_araddr[9:2];
    rdOk = (s_axi_araddr[1:0] == 2'h0) && (s_axi_araddr[TCRB_ADDR_W-1:10] == '0);
    case (rdIdx)
      TCRB_IDX_CONTROL: rdByte = ctrl;
      TCRB_IDX_MODE: rdByte = modeReg;
      TCRB_IDX_CAP_LOW: rdByte = capture[7:0];
      TCRB_IDX_CAP_HIGH: rdByte = capture[15:8];
      TCRB_IDX_CNT_LOW: rdByte = count[7:0];
      TCRB_IDX_CNT_HIGH: rdByte = count[15:8];
      TCRB_IDX_AUX: rdByte = aux;
      TCRB_IDX_IRQ_STATUS: rdByte = {6'h00, irqStatus};
      TCRB_IDX_IRQ_MASK: rdByte = {6'h00, irqMask};
      default: begin
        rdByte = 8'h00;
        rdOk = 1'b0;
      end
    endcase
  end

  // axi read channel: answer one cycle after the address is taken
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= TCRB_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rdByte};
      s_axi_rresp <= rdOk ? TCRB_RESP_OKAY : TCRB_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end else begin
      s_axi_arready <= !s_axi_rvalid;
    end
  end

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  AST_OVF_SETS: assert property (ovfSet |=> ctrl.overflowFlag)
    else $error("overflow did not set flag");
  AST_BAUD_NO_FLAG: assert property (baudMode && !doWrite && !ctrl.overflowFlag
    |=> !ctrl.overflowFlag)
    else $error("flag set in baud mode");
  AST_FLAG_STICKY: assert property (ctrl.overflowFlag && !doWrite |=> ctrl.overflowFlag)
    else $error("hardware cleared overflow flag");
  AST_EXT_SET: assert property (captureEvent || reloadEdge |=> ctrl.externalEdgeFlag)
    else $error("edge did not set external flag");
  AST_IRQ_REQ: assert property ($rose(ctrl.externalEdgeFlag) && aux[TCRB_AUX_IE_BIT]
    && $stable(aux) |=> timerIrqReq)
    else $error("request not raised");
  AST_IRQ_GATE: assert property (!aux[TCRB_AUX_IE_BIT] |=> !timerIrqReq)
    else $error("request passed while disabled");
  AST_RX_BASE: assert property (ctrl.rxBaudSelect && ovfEvent |=> rxBaudClk)
    else $error("receive base wrong");
  AST_TX_BASE: assert property (!ctrl.txBaudSelect |=> txBaudClk == $past(timer1Overflow))
    else $error("transmit base wrong");
  AST_IGNORE_PIN: assert property (!ctrl.extTriggerEnable |-> !edgeEvent)
    else $error("pin not ignored");
  AST_HOLD: assert property (!ctrl.runControl && !doWrite && !edgeEvent |=> $stable(count))
    else $error("count moved while stopped");
  AST_BAUD_RATE: assert property (baudMode && ctrl.runControl && advance
    |=> !advance ##1 (advance || !ctrl.runControl || !baudMode))
    else $error("baud rate not two clocks");
  AST_RELOAD: assert property (ovfEvent && countUp && !ctrl.captureReloadSelect && !doWrite
    |=> count == $past(capture))
    else $error("reload value wrong");
  AST_CAPTURE: assert property (captureEvent |=> capture == $past(count))
    else $error("capture value wrong");
  AST_CAP_CLEAR: assert property (captureEvent && modeReg[TCRB_MODE_CLR_BIT] && !doWrite
    |=> count == TCRB_RST_WORD)
    else $error("count not cleared on capture");
  AST_DIR: assert property (upDown && advance && !extPin.level && !ovfEvent && !doWrite
    |=> count == $past(count) - 16'h0001)
    else $error("down count wrong");

  COV_CAPTURE: cover property (captureEvent);
  COV_BAUD_OVF: cover property (baudMode && ovfEvent);
  COV_DOWN_MATCH: cover property (upDown && !countUp && ovfEvent);
  COV_IRQ: cover property ($rose(irqOut));
endmodule // tcrb_timer2
`default_nettype wire

// ### verif/tcrb_pins_model.sv
// far-side model: trigger and count pins, timer1 overflow source, serial port time-base sink
`timescale 1ns/1ps
`default_nettype none
module tcrb_pins_model (
  input wire logic sys_clk,
  input wire logic rxBaudClk,
  input wire logic txBaudClk,
  output logic extTriggerPin,
  output logic countInputPin,
  output logic timer1Overflow
);
  int rxSeen = 0; // receive time-base pulses seen by the serial port
  int txSeen = 0; // transmit time-base pulses seen by the serial port

  // pins idle high as the port pull-ups leave them
  initial begin
    extTriggerPin = 1'b1;
    countInputPin = 1'b1;
    timer1Overflow = 1'b0;
  end

  // serial port counts each one-cycle time-base pulse
  always @(posedge sys_clk) begin
    if (rxBaudClk === 1'b1) rxSeen <= rxSeen + 1;
    if (txBaudClk === 1'b1) txSeen <= txSeen + 1;
  end

  // hold the trigger pin at a level, which also sets the count direction
  task automatic set_trig(input logic v);
    @(posedge sys_clk);
    extTriggerPin <= v;
  endtask

  // falling edge wide enough to pass the three-stage pin filter
  task automatic pulse_trig();
    @(posedge sys_clk);
    extTriggerPin <= 1'b0;
    repeat (4) @(posedge sys_clk);
    extTriggerPin <= 1'b1;
    repeat (4) @(posedge sys_clk);
  endtask

  // n falling edges on the count pin, four clocks low and four high
  task automatic pulse_count(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      countInputPin <= 1'b0;
      repeat (4) @(posedge sys_clk);
      countInputPin <= 1'b1;
      repeat (3) @(posedge sys_clk);
    end
  endtask

  // one-cycle overflow pulse from timer1
  task automatic pulse_t1();
    @(posedge sys_clk);
    timer1Overflow <= 1'b1;
    @(posedge sys_clk);
    timer1Overflow <= 1'b0;
  endtask
endmodule // tcrb_pins_model
`default_nettype wire

// ### verif/tcrb_timer2_tb.sv
// self-checking testbench for the timer2 capture/reload/baud block
`timescale 1ns/1ps
`default_nettype none
module tcrb_timer2_tb
  import tcrb_pkg::*;
;
  logic sys_clk = 1'b0; // 125 MHz core clock
  logic reset_n = 1'b0; // active-low reset
  logic [TCRB_ADDR_W-1:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'hf; // writes cover the data byte except the strobe test in t_reset
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1; // master always accepts answers
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic extTriggerPin, countInputPin, timer1Overflow, rxBaudClk, txBaudClk, timerIrqReq, irqOut;
  int nFail = 0; // mismatches
  int totalChecks = 0; // comparisons made

  // clock: half period 4 ns
  always #4 sys_clk = ~sys_clk;

  tcrb_timer2 dut_u (.sys_clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .extTriggerPin, .countInputPin, .timer1Overflow,
    .rxBaudClk, .txBaudClk, .timerIrqReq, .irqOut);

  tcrb_pins_model pins_u (.sys_clk, .rxBaudClk, .txBaudClk, .extTriggerPin, .countInputPin,
    .timer1Overflow);

  // verdict and end of run
  task automatic summarize();
    $display("checks %0d mismatches %0d", totalChecks, nFail);
    if (nFail == 0 && totalChecks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // compare a byte value
  task automatic chkv(input logic [7:0] got, input logic [7:0] exp, input string msg);
    totalChecks++;
    if (got !== exp) begin
      $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
      nFail++;
    end
  endtask

  // compare a single output bit
  task automatic chkb(input logic got, input logic exp, input string msg);
    totalChecks++;
    if (got !== exp) begin
      $display("MISMATCH %0t %s got %b exp %b", $time, msg, got, exp);
      nFail++;
    end
  endtask

  // byte address is four times the register index
  function automatic logic [TCRB_ADDR_W-1:0] ad(input logic [7:0] i);
    return {2'b00, i, 2'b00};
  endfunction

  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // bus write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] i, input logic [7:0] d, output logic [1:0] r);
    int n;
    n = 0;
    s_axi_awaddr <= ad(i);
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 64);
    r = s_axi_bresp;
    if (n >= 64) chkb(1'b0, 1'b1, "write hang");
  endtask

  // bus read: address held until taken, data taken with rvalid
  task automatic rd(input logic [7:0] i, output logic [7:0] d, output logic [1:0] r);
    int n;
    n = 0;
    s_axi_araddr <= ad(i);
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 64);
    d = s_axi_rdata[7:0];
    r = s_axi_rresp;
    if (n >= 64) chkb(1'b0, 1'b1, "read hang");
  endtask

  // write expecting an okay response
  task automatic w(input logic [7:0] i, input logic [7:0] d);
    logic [1:0] r;
    wr(i, d, r);
    chkv({6'h00, r}, {6'h00, TCRB_RESP_OKAY}, "write resp");
  endtask

  // read and compare against an expected byte
  task automatic rc(input logic [7:0] i, input logic [7:0] e);
    logic [7:0] d;
    logic [1:0] r;
    rd(i, d, r);
    chkv({6'h00, r}, {6'h00, TCRB_RESP_OKAY}, "read resp");
    chkv(d, e, "read data");
  endtask

  // reset values of all registers, unmapped address refused
  task automatic t_reset();
    logic [7:0] regs[9];
    logic [7:0] d;
    logic [1:0] r;
    regs = '{TCRB_IDX_CONTROL, TCRB_IDX_MODE, TCRB_IDX_CAP_LOW, TCRB_IDX_CAP_HIGH, TCRB_IDX_CNT_LOW,
      TCRB_IDX_CNT_HIGH, TCRB_IDX_AUX, TCRB_IDX_IRQ_STATUS, TCRB_IDX_IRQ_MASK};
    foreach (regs[k]) rc(regs[k], TCRB_RST_BYTE);
    rd(8'h00, d, r);
    chkv({6'h00, r}, {6'h00, TCRB_RESP_SLVERR}, "unmapped read resp");
    chkv(d, 8'h00, "unmapped read data");
    wr(8'h00, 8'h5a, r);
    chkv({6'h00, r}, {6'h00, TCRB_RESP_SLVERR}, "unmapped write resp");
    // write without the data byte strobe is answered but changes nothing
    s_axi_wstrb <= 4'he;
    w(TCRB_IDX_MODE, 8'h5a);
    s_axi_wstrb <= 4'hf;
    rc(TCRB_IDX_MODE, TCRB_RST_BYTE);
  endtask

  // stopped timer keeps its count
  task automatic t_freeze();
    w(TCRB_IDX_AUX, 8'h01);
    w(TCRB_IDX_CNT_LOW, 8'h10);
    idle(50);
    rc(TCRB_IDX_CNT_LOW, 8'h10);
  endtask

  // overflow reload, sticky flag, status, mask and enable gating
  task automatic t_reload();
    w(TCRB_IDX_CAP_LOW, 8'h34);
    w(TCRB_IDX_CAP_HIGH, 8'h12);
    w(TCRB_IDX_CNT_LOW, 8'hfe);
    w(TCRB_IDX_CNT_HIGH, 8'hff);
    w(TCRB_IDX_CONTROL, 8'h04);
    idle(24);
    rc(TCRB_IDX_CONTROL, 8'h84);
    rc(TCRB_IDX_CNT_HIGH, 8'h12);
    chkb(timerIrqReq, 1'b0, "request while disabled");
    chkb(irqOut, 1'b0, "irq while masked");
    rc(TCRB_IDX_IRQ_STATUS, 8'h01);
    w(TCRB_IDX_IRQ_MASK, 8'h01);
    idle(2);
    chkb(irqOut, 1'b1, "irq unmasked");
    w(TCRB_IDX_IRQ_STATUS, 8'h01);
    idle(2);
    chkb(irqOut, 1'b0, "irq after clear");
    rc(TCRB_IDX_IRQ_STATUS, 8'h00);
    w(TCRB_IDX_AUX, 8'h03);
    idle(2);
    chkb(timerIrqReq, 1'b1, "request with flag held");
    w(TCRB_IDX_CONTROL, 8'h00);
    idle(2);
    chkb(timerIrqReq, 1'b0, "request after software clear");
    rc(TCRB_IDX_CONTROL, 8'h00);
  endtask

  // trigger ignored, capture with clear, reload on edge
  task automatic t_capture();
    w(TCRB_IDX_CNT_LOW, 8'h78);
    w(TCRB_IDX_CNT_HIGH, 8'h56);
    w(TCRB_IDX_CONTROL, 8'h01);
    pins_u.pulse_trig();
    rc(TCRB_IDX_CAP_LOW, 8'h34);
    rc(TCRB_IDX_CONTROL, 8'h01);
    w(TCRB_IDX_CONTROL, 8'h09);
    w(TCRB_IDX_MODE, 8'h08);
    pins_u.pulse_trig();
    rc(TCRB_IDX_CAP_LOW, 8'h78);
    rc(TCRB_IDX_CAP_HIGH, 8'h56);
    rc(TCRB_IDX_CNT_LOW, 8'h00);
    rc(TCRB_IDX_CNT_HIGH, 8'h00);
    rc(TCRB_IDX_CONTROL, 8'h49);
    chkb(timerIrqReq, 1'b1, "request on edge");
    rc(TCRB_IDX_IRQ_STATUS, 8'h02);
    w(TCRB_IDX_MODE, 8'h00);
    w(TCRB_IDX_CONTROL, 8'h08);
    pins_u.pulse_trig();
    rc(TCRB_IDX_CNT_LOW, 8'h78);
    rc(TCRB_IDX_CNT_HIGH, 8'h56);
    rc(TCRB_IDX_CONTROL, 8'h48);
    w(TCRB_IDX_CONTROL, 8'h00);
    w(TCRB_IDX_IRQ_STATUS, 8'h03);
  endtask

  // counter mode, up with pin high and down with pin low
  task automatic t_counter();
    w(TCRB_IDX_CNT_LOW, 8'h05);
    w(TCRB_IDX_CNT_HIGH, 8'h00);
    w(TCRB_IDX_CAP_LOW, 8'h00);
    w(TCRB_IDX_CAP_HIGH, 8'h00);
    w(TCRB_IDX_MODE, 8'h01);
    w(TCRB_IDX_CONTROL, 8'h06);
    pins_u.pulse_count(3);
    rc(TCRB_IDX_CNT_LOW, 8'h08);
    pins_u.set_trig(1'b0);
    idle(6);
    pins_u.pulse_count(3);
    rc(TCRB_IDX_CNT_LOW, 8'h05);
    rc(TCRB_IDX_CONTROL, 8'h06);
    // down to the capture value: match reloads all ones and sets both flags
    pins_u.pulse_count(6);
    rc(TCRB_IDX_CNT_HIGH, 8'hff);
    rc(TCRB_IDX_CONTROL, 8'hc6);
    pins_u.set_trig(1'b1);
    w(TCRB_IDX_CONTROL, 8'h00);
    w(TCRB_IDX_MODE, 8'h00);
  endtask

  // baud generator: one overflow per 16 ticks of 2 clocks, no flags
  task automatic t_baud();
    int r0;
    int t0;
    w(TCRB_IDX_CAP_LOW, 8'hf0);
    w(TCRB_IDX_CAP_HIGH, 8'hff);
    w(TCRB_IDX_CNT_LOW, 8'hf0);
    w(TCRB_IDX_CNT_HIGH, 8'hff);
    w(TCRB_IDX_CONTROL, 8'h34);
    r0 = pins_u.rxSeen;
    t0 = pins_u.txSeen;
    // ten overflows land in this span, the first one period in and the last half a period before its end
    idle(336);
    chkv(8'(pins_u.rxSeen - r0), 8'd10, "rx time base");
    chkv(8'(pins_u.txSeen - t0), 8'd10, "tx time base");
    rc(TCRB_IDX_CONTROL, 8'h34);
    w(TCRB_IDX_CONTROL, 8'h14);
    r0 = pins_u.rxSeen;
    repeat (3) pins_u.pulse_t1();
    idle(3);
    chkv(8'(pins_u.rxSeen - r0), 8'd3, "rx from timer1");
    w(TCRB_IDX_CONTROL, 8'h24);
    t0 = pins_u.txSeen;
    repeat (2) pins_u.pulse_t1();
    idle(3);
    chkv(8'(pins_u.txSeen - t0), 8'd2, "tx from timer1");
    w(TCRB_IDX_CONTROL, 8'h00);
  endtask

  // watchdog cuts a hang short
  initial begin
    idle(20000);
    nFail++;
    summarize();
  end

  // main sequence
  initial begin
    idle(20);
    reset_n <= 1'b1;
    idle(1);
    t_reset();
    t_freeze();
    t_reload();
    t_capture();
    t_counter();
    t_baud();
    summarize();
  end
endmodule // tcrb_timer2_tb
`default_nettype wire
